// file: inc/epi_cfg.svh
// Register indices, field positions and fixed values of the external pin interrupt frame.
// Assumes a byte-indexed frame placed on a 32-bit APB bus, one register per aligned word.
`ifndef EPI_CFG_SVH
`define EPI_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define EPI_IDX_FIRST_PIN_CTRL  8'h70
`define EPI_IDX_FIRST_PIN_FLAG  8'h71
`define EPI_IDX_POWER_GROUP1_ENABLE      8'h7E
`define EPI_IDX_POWER_GROUP1_FLAGS       8'h7F
`define EPI_ADDR_W              10

// Field positions of a pin control byte and a pin flag byte.
`define EPI_B_EDGE_FLAG         7
`define EPI_B_LEVEL_VIEW        6
`define EPI_B_NMI_SEL           5
`define EPI_B_DIRECTION         4
`define EPI_B_OUT_VALUE         3
`define EPI_B_POLARITY          2
`define EPI_B_PRIORITY          1
`define EPI_B_IRQ_ENABLE        0

// Field positions of a power group enable and flag byte.
`define EPI_B_GROUP_ENABLE      7
`define EPI_B_GROUP_FLAG        7
`define EPI_PM_SOURCES          7

// Reset values and the fallback vector.
`define EPI_CTRL_RESET          6'h00
`define EPI_PM_ENABLE_RESET     8'h00
`define EPI_PHANTOM_VECTOR      16'h8004

`endif

// file: inc/epi_pkg.sv
// Types shared by the external pin and power fault interrupt frame.
// Assumes the constants of epi_cfg.svh are included by the design files.
package epi_pkg;

  // Kinds of external interrupt pin.
  typedef enum logic [1:0] {EPI_TYPE_A, EPI_TYPE_B, EPI_TYPE_C} epi_pin_type_e;

  // Interrupt lines towards the CPU core.
  typedef enum logic [1:0] {EPI_LVL_NMI, EPI_LVL_HIGH, EPI_LVL_LOW} epi_level_e;

  // Stored control bits of one pin.
  typedef struct packed {
    logic nmi_sel;
    logic direction;
    logic out_value;
    logic polarity;
    logic prio_low;
    logic irq_enable;
  } epi_pin_ctrl_s;

  // Answer to an interrupt acknowledge.
  typedef struct packed {
    logic        phantom;
    logic [1:0]  source;
    logic [15:0] vector;
  } epi_ack_s;

endpackage : epi_pkg

// file: hdl/epi_frame.sv
// External pin and power fault interrupt frame with APB register access and acknowledge search.
// Assumes pins and fault inputs are synchronous to clk and the CPU pulses ack_req once per acknowledge.
// How it works
// - Pin edge flag bit 7 sets on the selected edge, even when disabled.
// - Edge flag stays set until software clear or system reset.
// - Every selected edge on an enabled or NMI pin raises a request, even with the flag already set.
// - Clearing the edge flag cancels that pin's pending request.
// - Edge flag lives in its own byte apart from control bits.
// - Writes to flag byte bits 6-0 do nothing; they read zero here.
// - Control bit 6 always shows the live pin level.
// - NMI select raises nonmaskable requests and overrides priority and enable.
// - Pins B and C without interrupt use are input or output by direction.
// - Digital output pins drive the output-value bit, readable and writable.
// - Polarity 0 detects falling edges, 1 detects rising edges.
// - Priority 0 routes to the high line, 1 to the low line.
// - Enable 1 permits maskable requests; 0 leaves plain digital I/O.
// - Type C pins have no NMI; priority and enable always act.
// - First Type A pair sits at 70h/71h; further pairs follow.
// - Seven fault sources per group, each with enable and status, fixed level.
// - Group enable 0 blocks all group requests and the wakeup.
// - A source requests only with its own and the group enable set.
// - Group flag sets on any enabled active source; write 0 clears it.
// - Status bits 6-0 are read-only live source states.
// - Acknowledge finding no pending source returns the phantom vector.
// - Type A pins have no direction or output bit; input only.
// - Type C NMI select is constantly zero.
`timescale 1ns/100ps
`include "epi_cfg.svh"

module epi_frame
  import epi_pkg::*;
#(
  parameter int                NUM_PINS               = 3,
  parameter epi_pin_type_e     PIN_TYPE [0:NUM_PINS-1] = '{EPI_TYPE_A, EPI_TYPE_B, EPI_TYPE_C},
  parameter epi_level_e        PM_LEVEL               = EPI_LVL_HIGH
)
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`EPI_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [NUM_PINS-1:0]      pin_in,
  output logic      [NUM_PINS-1:0]      pin_out,
  output logic      [NUM_PINS-1:0]      pin_oe,
  input  wire logic [`EPI_PM_SOURCES-1:0] pm_source_status,
  output logic                          irq_nmi,
  output logic                          irq_high,
  output logic                          irq_low,
  output logic                          pm_wakeup,
  input  wire logic                     ack_req,
  input  wire epi_level_e               ack_level,
  output logic                          ack_valid,
  output epi_ack_s                      ack_answer
);

  logic                          rst_meta_reg;
  logic                          rst_n_reg;
  epi_pin_ctrl_s                 ctrl_reg [NUM_PINS];
  logic [NUM_PINS-1:0]           flag_reg;
  logic [NUM_PINS-1:0]           pend_reg;
  logic [NUM_PINS-1:0]           sync1_reg;
  logic [NUM_PINS-1:0]           sync2_reg;
  logic [NUM_PINS-1:0]           sync3_reg;
  logic [NUM_PINS-1:0]           edge_evt;
  logic [NUM_PINS-1:0]           nmi_eff;
  logic [NUM_PINS-1:0]           flag_clr;
  logic [NUM_PINS-1:0]           ctrl_wr;
  logic [NUM_PINS-1:0]           ack_clr;
  logic [`EPI_PM_SOURCES-1:0]    pm_src_en_reg;
  logic                          pm_group_en_reg;
  logic                          pm_flag_reg;
  logic                          pm_active;
  logic                          pm_req;
  logic [7:0]                    reg_idx;
  logic                          wr_access;
  logic                          rd_setup;
  logic                          addr_hit;
  logic [7:0]                    rd_byte;
  epi_ack_s                      ack_next;
  logic [NUM_PINS-1:0]           ack_clr_next;

  // Reset is released through two flip-flops so that its removal is clean against clk.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // The slave always answers in the access cycle, so there are no wait states.
  assign reg_idx   = paddr[`EPI_ADDR_W-1:2];
  assign wr_access = psel && penable && pwrite && addr_hit;
  assign rd_setup  = psel && !penable && !pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_hit;

  // Pin pairs follow the first Type A pair; the power group sits at the top of the frame.
  assign addr_hit = (paddr[1:0] == 2'h0) &&
                    ((reg_idx == `EPI_IDX_POWER_GROUP1_ENABLE) || (reg_idx == `EPI_IDX_POWER_GROUP1_FLAGS) ||
                     ((reg_idx >= `EPI_IDX_FIRST_PIN_CTRL) &&
                      (reg_idx < `EPI_IDX_FIRST_PIN_CTRL + 8'(2 * NUM_PINS))));

  // Read data is gathered in the setup cycle and held in a flip-flop for the access cycle.
  always_comb
  begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (reg_idx == `EPI_IDX_FIRST_PIN_CTRL + 8'(2 * i))
        rd_byte = {1'b0, sync2_reg[i], ctrl_reg[i]};
      if (reg_idx == `EPI_IDX_FIRST_PIN_FLAG + 8'(2 * i))
        rd_byte[`EPI_B_EDGE_FLAG] = flag_reg[i];
    end
    if (reg_idx == `EPI_IDX_POWER_GROUP1_ENABLE)
      rd_byte = {pm_group_en_reg, pm_src_en_reg};
    if (reg_idx == `EPI_IDX_POWER_GROUP1_FLAGS)
      rd_byte = {pm_flag_reg, pm_source_status};
  end

  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= {24'h00_0000, addr_hit ? rd_byte : 8'h00};
  end

  // Per-pin write strobes; a control write never touches the flag because it is another byte.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      ctrl_wr[i]  = wr_access && (reg_idx == `EPI_IDX_FIRST_PIN_CTRL + 8'(2 * i));
      flag_clr[i] = wr_access && (reg_idx == `EPI_IDX_FIRST_PIN_FLAG + 8'(2 * i)) &&
                    !pwdata[`EPI_B_EDGE_FLAG];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_pin
      // Three stages: two synchronise, the third holds the previous sample for edge detection.
      always_ff @(posedge clk or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
        begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
        end
        else
        begin
          sync1_reg[g] <= pin_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end

      // Polarity picks the transition; each transition yields one single-cycle event.
      assign edge_evt[g] = ctrl_reg[g].polarity ? (sync2_reg[g] && !sync3_reg[g])
                                                : (!sync2_reg[g] && sync3_reg[g]);

      // Type C keeps no NMI select at all.
      assign nmi_eff[g] = (PIN_TYPE[g] != EPI_TYPE_C) && ctrl_reg[g].nmi_sel;

      // Control bits; bits absent from a pin type are never stored and read zero.
      always_ff @(posedge clk or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          ctrl_reg[g] <= `EPI_CTRL_RESET;
        else if (ctrl_wr[g])
        begin
          ctrl_reg[g].nmi_sel    <= (PIN_TYPE[g] != EPI_TYPE_C) && pwdata[`EPI_B_NMI_SEL];
          ctrl_reg[g].direction  <= (PIN_TYPE[g] != EPI_TYPE_A) && pwdata[`EPI_B_DIRECTION];
          ctrl_reg[g].out_value  <= (PIN_TYPE[g] != EPI_TYPE_A) && pwdata[`EPI_B_OUT_VALUE];
          ctrl_reg[g].polarity   <= pwdata[`EPI_B_POLARITY];
          ctrl_reg[g].prio_low   <= pwdata[`EPI_B_PRIORITY];
          ctrl_reg[g].irq_enable <= pwdata[`EPI_B_IRQ_ENABLE];
        end
      end

      // The flag sets on any selected edge; an edge in the clearing cycle wins.
      always_ff @(posedge clk or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          flag_reg[g] <= 1'b0;
        else if (edge_evt[g])
          flag_reg[g] <= 1'b1;
        else if (flag_clr[g])
          flag_reg[g] <= 1'b0;
      end

      // A request pends per edge regardless of the flag, and dies on acknowledge or flag clear.
      always_ff @(posedge clk or negedge rst_n_reg)
      begin
        if (!rst_n_reg)
          pend_reg[g] <= 1'b0;
        else if (edge_evt[g] && (nmi_eff[g] || ctrl_reg[g].irq_enable))
          pend_reg[g] <= 1'b1;
        else if (flag_clr[g] || ack_clr[g])
          pend_reg[g] <= 1'b0;
      end

      // The pin drives only as a digital output, never while serving as an interrupt.
      assign pin_oe[g]  = (PIN_TYPE[g] != EPI_TYPE_A) && ctrl_reg[g].direction &&
                          !nmi_eff[g] && !ctrl_reg[g].irq_enable;
      assign pin_out[g] = ctrl_reg[g].out_value;

      // Checks for each pin.
      property p_flag_sets;
        @(posedge clk) disable iff (!rst_n_reg) edge_evt[g] |=> flag_reg[g];
      endproperty
      a_flag_sets : assert property (p_flag_sets) else $error("edge flag did not set");
      property p_flag_holds;
        @(posedge clk) disable iff (!rst_n_reg) flag_reg[g] && !flag_clr[g] |=> flag_reg[g];
      endproperty
      a_flag_holds : assert property (p_flag_holds) else $error("edge flag lost");
      property p_edge_requests;
        @(posedge clk) disable iff (!rst_n_reg)
          edge_evt[g] && flag_reg[g] && (nmi_eff[g] || ctrl_reg[g].irq_enable) |=> pend_reg[g];
      endproperty
      a_edge_requests : assert property (p_edge_requests) else $error("edge with flag set lost");
      property p_clear_cancels;
        @(posedge clk) disable iff (!rst_n_reg) flag_clr[g] && !edge_evt[g] |=> !pend_reg[g] && !flag_reg[g];
      endproperty
      a_clear_cancels : assert property (p_clear_cancels) else $error("flag clear left request");
      property p_ctrl_write_keeps_flag;
        @(posedge clk) disable iff (!rst_n_reg) ctrl_wr[g] && !edge_evt[g] |=> $stable(flag_reg[g]);
      endproperty
      a_ctrl_write_keeps_flag : assert property (p_ctrl_write_keeps_flag) else $error("control write hit flag");
      property p_nmi_route;
        @(posedge clk) disable iff (!rst_n_reg) pend_reg[g] && nmi_eff[g] |-> irq_nmi;
      endproperty
      a_nmi_route : assert property (p_nmi_route) else $error("nmi request not routed");
      property p_output_drive;
        @(posedge clk) disable iff (!rst_n_reg)
          ctrl_wr[g] && pwdata[`EPI_B_DIRECTION] && !pwdata[`EPI_B_IRQ_ENABLE] && !pwdata[`EPI_B_NMI_SEL] &&
          (PIN_TYPE[g] != EPI_TYPE_A) |=> pin_oe[g] && (pin_out[g] == $past(pwdata[`EPI_B_OUT_VALUE]));
      endproperty
      a_output_drive : assert property (p_output_drive) else $error("output pin not driven");
    end
  endgenerate

  // Maskable requests split by priority; NMI pins bypass priority and enable.
  always_comb
  begin
    irq_nmi  = |(pend_reg & nmi_eff);
    irq_high = 1'b0;
    irq_low  = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pend_reg[i] && !nmi_eff[i] && ctrl_reg[i].irq_enable)
      begin
        irq_high = irq_high || !ctrl_reg[i].prio_low;
        irq_low  = irq_low || ctrl_reg[i].prio_low;
      end
    end
    if (pm_req)
    begin
      irq_nmi  = irq_nmi || (PM_LEVEL == EPI_LVL_NMI);
      irq_high = irq_high || (PM_LEVEL == EPI_LVL_HIGH);
      irq_low  = irq_low || (PM_LEVEL == EPI_LVL_LOW);
    end
  end

  // Power group: the level is fixed by parameter; the request follows the fault levels directly.
  assign pm_active = |(pm_source_status & pm_src_en_reg);
  assign pm_req    = pm_group_en_reg && pm_active;
  assign pm_wakeup = pm_req;

  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      {pm_group_en_reg, pm_src_en_reg} <= `EPI_PM_ENABLE_RESET;
    else if (wr_access && (reg_idx == `EPI_IDX_POWER_GROUP1_ENABLE))
      {pm_group_en_reg, pm_src_en_reg} <= pwdata[7:0];
  end

  // The group flag latches any enabled active source; writing 0 clears, a new event wins.
  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      pm_flag_reg <= 1'b0;
    else if (pm_active)
      pm_flag_reg <= 1'b1;
    else if (wr_access && (reg_idx == `EPI_IDX_POWER_GROUP1_FLAGS) && !pwdata[`EPI_B_GROUP_FLAG])
      pm_flag_reg <= 1'b0;
  end

  // Acknowledge search walks the chain in pin order, then the power group, else phantom.
  always_comb
  begin
    ack_next     = '{phantom: 1'b1, source: 2'h0, vector: `EPI_PHANTOM_VECTOR};
    ack_clr_next = '0;
    if (pm_req && (PM_LEVEL == ack_level))
      ack_next = '{phantom: 1'b0, source: 2'(NUM_PINS), vector: 16'h0000};
    for (int i = NUM_PINS - 1; i >= 0; i--)
    begin
      if (pend_reg[i] && ((nmi_eff[i] && (ack_level == EPI_LVL_NMI)) ||
          (!nmi_eff[i] && ctrl_reg[i].irq_enable &&
           ((ctrl_reg[i].prio_low ? EPI_LVL_LOW : EPI_LVL_HIGH) == ack_level))))
      begin
        ack_next     = '{phantom: 1'b0, source: 2'(i), vector: 16'h0000};
        ack_clr_next = '0;
        ack_clr_next[i] = 1'b1;
      end
    end
  end

  assign ack_clr = ack_req ? ack_clr_next : '0;

  // The answer is registered so it is valid exactly one cycle after the request.
  always_ff @(posedge clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ack_valid  <= 1'b0;
      ack_answer <= '0;
    end
    else
    begin
      ack_valid <= ack_req;
      if (ack_req)
        ack_answer <= ack_next;
    end
  end

  property p_group_gate;
    @(posedge clk) disable iff (!rst_n_reg) !pm_group_en_reg |-> !pm_wakeup;
  endproperty
  a_group_gate : assert property (p_group_gate) else $error("disabled group woke");
  property p_group_flag;
    @(posedge clk) disable iff (!rst_n_reg) pm_active |=> pm_flag_reg;
  endproperty
  a_group_flag : assert property (p_group_flag) else $error("group flag missed");
  property p_phantom;
    @(posedge clk) disable iff (!rst_n_reg)
      ack_req && (pend_reg == '0) && !pm_req |=> ack_valid && ack_answer.phantom &&
      (ack_answer.vector == `EPI_PHANTOM_VECTOR);
  endproperty
  a_phantom : assert property (p_phantom) else $error("phantom vector not given");
  property p_level_view;
    @(posedge clk) disable iff (!rst_n_reg)
      rd_setup && (reg_idx == `EPI_IDX_FIRST_PIN_CTRL) |=> prdata[`EPI_B_LEVEL_VIEW] == $past(sync2_reg[0]);
  endproperty
  a_level_view : assert property (p_level_view) else $error("pin level view wrong");
  c_flag_set : cover property (@(posedge clk) disable iff (!rst_n_reg) $rose(flag_reg[0]));
  c_phantom : cover property (@(posedge clk) disable iff (!rst_n_reg) ack_valid && ack_answer.phantom);
  c_pm_flag : cover property (@(posedge clk) disable iff (!rst_n_reg) $rose(pm_flag_reg));

endmodule : epi_frame

// file: verification/epi_cpu_model.sv
// CPU core side of the interrupt acknowledge handshake.
// Assumes the frame answers each acknowledge with a one-cycle valid pulse and holds the answer after it.
`timescale 1ns/100ps

module epi_cpu_model
  import epi_pkg::*;
(
  input  wire logic     clk,
  output logic          ack_req,
  output epi_level_e    ack_level,
  input  wire logic     ack_valid,
  input  wire epi_ack_s ack_answer
);

  // The request line idles low from time zero.
  initial
  begin
    ack_req   = 1'h0;
    ack_level = EPI_LVL_NMI;
  end

  // One acknowledge after a chosen delay, so both a prompt and a slow core are seen.
  // The wait for valid is bounded because a lost answer must not hang the run.
  task automatic acknowledge(input epi_level_e lvl, input int dly, output epi_ack_s ans, output logic ok);
    int n;
    repeat (dly) @(posedge clk);
    ack_req   <= 1'h1;
    ack_level <= lvl;
    @(posedge clk);
    ack_req <= 1'h0;
    ok = 1'h0;
    n  = 0;
    while (!ok && n < 8)
    begin
      @(posedge clk);
      ok  = (ack_valid === 1'h1);
      ans = ack_answer;
      n++;
    end
  endtask : acknowledge

endmodule : epi_cpu_model

// file: verification/tb.sv
// Self-checking bench of the pin and power fault interrupt frame.
// Assumes the frame's defaults: pins of types A, B, C and the power group on the high line.
`timescale 1ns/100ps
`include "epi_cfg.svh"

module tb
  import epi_pkg::*;
;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        irq_nmi, irq_high, irq_low, pm_wakeup, ack_req, ack_valid;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  pin_drv, pin_prev, pin_out, pin_oe;
  wire  [2:0]  pin_in;
  logic [6:0]  pm_st;
  logic        e;
  epi_level_e  ack_level;
  epi_ack_s    ack_answer;
  int          error_cnt, compares, cyc, m_pmen, m_pmflag;
  int          m_ctrl [3];
  int          m_flag [3];
  int          m_pend [3];
  localparam logic [5:0] MASK [3] = '{6'h27, 6'h3F, 6'h1F};

  // A pin that the frame drives shows its own output level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);

  epi_frame dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pm_source_status(pm_st), .irq_nmi(irq_nmi), .irq_high(irq_high), .irq_low(irq_low),
    .pm_wakeup(pm_wakeup), .ack_req(ack_req), .ack_level(ack_level), .ack_valid(ack_valid),
    .ack_answer(ack_answer));

  epi_cpu_model cpu (.clk(clk), .ack_req(ack_req), .ack_level(ack_level), .ack_valid(ack_valid),
    .ack_answer(ack_answer));

  // Clock at 100 MHz.
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Reference model of edges and the group flag; it sees edges at once, the frame a few cycles later.
  always @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
      if (resetn === 1'h1 && pin_prev[i] !== pin_in[i] && pin_in[i] === m_ctrl[i][2])
      begin
        m_flag[i] <= 1;
        if (m_ctrl[i][5] || m_ctrl[i][0])
          m_pend[i] <= 1;
      end
    pin_prev <= pin_in;
    if (|(pm_st & m_pmen[6:0]))
      m_pmflag <= 1;
  end

  // Hang guard.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; entered just after a rising edge, holds everything until pready is seen.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // Control writes wait out any edge that a change of drive causes.
  // The model takes the new bits first, so an edge from a change of drive is judged with the new polarity.
  task automatic wr_ctrl(input int i, input logic [5:0] d);
    m_ctrl[i] = d & MASK[i];
    apb(1'h1, 10'h1C0 + 10'(8 * i), 32'(d));
    repeat (4) @(posedge clk);
  endtask : wr_ctrl

  task automatic wr_flag(input int i, input logic [7:0] d);
    apb(1'h1, 10'h1C4 + 10'(8 * i), 32'(d));
    if (!d[7])
    begin
      m_flag[i] = 0;
      m_pend[i] = 0;
    end
  endtask : wr_flag

  task automatic set_pin(input int i, input logic v);
    pin_drv[i] <= v;
    repeat (4) @(posedge clk);
  endtask : set_pin

  // Reads every register and compares them and the pin drive, slave error, interrupt and wakeup outputs with the model.
  task automatic check_all();
    logic [3:0] v;
    logic [2:0] oe, ov;
    v = 4'h0;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'h0, 10'h1C0 + 10'(8 * i), 32'h0);
      chk("control", r, 32'(m_ctrl[i]) | (32'(pin_in[i]) << 6));
      apb(1'h0, 10'h1C4 + 10'(8 * i), 32'h0);
      chk("edge flag", r, 32'(m_flag[i]) << 7);
      oe[i] = m_ctrl[i][4] & ~m_ctrl[i][0] & ~m_ctrl[i][5];
      ov[i] = m_ctrl[i][3];
      if (m_pend[i])
        v[m_ctrl[i][5] ? 3 : m_ctrl[i][1] ? 1 : 2] = 1'h1;
    end
    v[0] = m_pmen[7] & (|(pm_st & m_pmen[6:0]));
    v[2] = v[2] | v[0];
    apb(1'h0, 10'h1F8, 32'h0);
    chk("power enable", r, 32'(m_pmen));
    apb(1'h0, 10'h1FC, 32'h0);
    chk("power flags", r, {24'h0, 1'(m_pmflag), pm_st});
    chk("slave error", 32'(e), 32'h0);
    chk("drive", 32'(pin_oe), 32'(oe));
    chk("output", 32'(pin_out), 32'(ov));
    chk("lines", 32'({irq_nmi, irq_high, irq_low, pm_wakeup}), 32'(v));
  endtask : check_all

  // Acknowledge at one level; the lowest pending pin wins, then the power group, else the fallback.
  task automatic ack(input epi_level_e lv);
    epi_ack_s ans;
    logic     ok;
    int       src;
    src = -1;
    for (int i = 2; i >= 0; i--)
      if (m_pend[i] != 0 && (m_ctrl[i][5] ? 0 : m_ctrl[i][1] ? 2 : 1) == int'(lv))
        src = i;
    if (src < 0 && lv == EPI_LVL_HIGH && m_pmen[7] && (|(pm_st & m_pmen[6:0])))
      src = 3;
    cpu.acknowledge(lv, int'($urandom % 3), ans, ok);
    if (src >= 0 && src < 3)
      m_pend[src] = 0;
    chk("ack valid", 32'(ok), 32'h1);
    chk("ack answer", src < 0 ? {13'h0, ans} : {13'h0, ans.phantom, ans.source, 16'h0},
      src < 0 ? {13'h0, 1'h1, 2'h0, `EPI_PHANTOM_VECTOR} : {13'h0, 1'h0, 2'(src), 16'h0});
  endtask : ack

  // Main sequence.
  initial
  begin
    resetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 10'h0; pwdata = 32'h0;
    pin_drv = 3'h0; pin_prev = 3'h0; pm_st = 7'h0;
    void'($urandom(66));
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    check_all();
    apb(1'h0, 10'h1D8, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    chk("ready", 32'(pready), 32'h1);
    $display("test reset done");
    wr_ctrl(1, 6'h18);
    check_all();
    // Edge detection with the interrupt disabled, both polarities on every pin.
    for (int i = 0; i < 3; i++)
      for (int p = 1; p >= 0; p--)
      begin
        wr_ctrl(i, 6'(p << 2));
        set_pin(i, p[0]);
        check_all();
        wr_flag(i, 8'hFF);
        check_all();
        wr_flag(i, 8'h00);
        check_all();
      end
    $display("test edges done");
    wr_ctrl(1, 6'h05);
    set_pin(1, 1'h1);
    ack(EPI_LVL_HIGH);
    set_pin(1, 1'h0);
    set_pin(1, 1'h1);
    check_all();
    wr_flag(1, 8'h00);
    check_all();
    ack(EPI_LVL_HIGH);
    wr_ctrl(2, 6'h23);
    set_pin(2, 1'h1);
    set_pin(2, 1'h0);
    wr_ctrl(0, 6'h24);
    set_pin(0, 1'h0);
    set_pin(0, 1'h1);
    check_all();
    ack(EPI_LVL_LOW);
    ack(EPI_LVL_NMI);
    ack(EPI_LVL_NMI);
    wr_ctrl(0, 6'h05);
    set_pin(0, 1'h0);
    set_pin(0, 1'h1);
    set_pin(1, 1'h0);
    set_pin(1, 1'h1);
    ack(EPI_LVL_HIGH);
    ack(EPI_LVL_HIGH);
    check_all();
    $display("test interrupts done");
    // Power group with random sources; even rounds keep the group disabled.
    for (int k = 0; k < 6; k++)
    begin
      pm_st <= 7'h0;
      repeat (3) @(posedge clk);
      m_pmen = k[0] ? int'(8'($urandom) | 8'h80) : int'(8'($urandom) & 8'h7F);
      apb(1'h1, 10'h1F8, 32'(m_pmen));
      pm_st <= 7'($urandom);
      repeat (3) @(posedge clk);
      check_all();
      ack(EPI_LVL_HIGH);
      apb(1'h1, 10'h1FC, 32'h80);
      check_all();
      apb(1'h1, 10'h1FC, 32'h00);
      m_pmflag = 0;
      repeat (2) @(posedge clk);
      check_all();
    end
    $display("test power group done");
    stop_test();
  end

endmodule : tb
